// *** vfrc_pkg.sv ***
// Purpose: Shared constants and types for the output fault-response controller.
// Assumes: 50 MHz system clock, management-bus commands decoded upstream into byte/word transfers.
// Notes: Thresholds use unsigned 16-bit volts scaled by 2^-13.
//
// What this block does
// - Action codes 00/01 unused; 10/11 disable output, then follow retry setting.
// - A fault pulls alert line low and sets a sticky status bit until clear-faults.
// - Overvoltage with retry 000 keeps output off until device reset.
// - Undervoltage with retry 000 keeps output off until faults cleared.
// - Retry 111 restarts forever until turned off, bias lost, other fault; 001-110 unused.
// - Retry interval is (delay field + 1) times 35 ms, 35 to 280 ms.
// - Interval runs from start of one restart attempt to start of next.
// - Both fault-action registers reset to 80h, shutdown with no retry.
// - Undervoltage detection masked while ramping, before power-good, and while disabled.
// - Undervoltage threshold resets to 0.85 times the strapped setpoint voltage.
// - Each output page keeps its own settings; accesses use the selected page.
// - Fault actions are one-byte transfers; undervoltage threshold is a two-byte word.
package vfrc_pkg;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OV_FAULT_ACTION = 8'h41;
  localparam logic [7:0] CMD_UV_FAULT_THRESHOLD = 8'h44;
  localparam logic [7:0] CMD_UV_FAULT_ACTION = 8'h45;

  // ----------------------------------------------------------------------
  // Transfer lengths in bytes
  // ----------------------------------------------------------------------
  localparam logic [1:0] LEN_SEND = 2'h0;
  localparam logic [1:0] LEN_BYTE = 2'h1;
  localparam logic [1:0] LEN_WORD = 2'h2;

  // ----------------------------------------------------------------------
  // Fault-action field layout and reset value
  // ----------------------------------------------------------------------
  localparam int ACT_MODE_HI = 7;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_DELAY_HI = 2;
  localparam int ACT_DELAY_LO = 0;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [7:0] ACT_RESET = 8'h80;

  // ----------------------------------------------------------------------
  // Threshold default scaling: 0.85 = 17 / 20
  // ----------------------------------------------------------------------
  localparam int UV_SCALE_NUM = 17;
  localparam int UV_SCALE_DEN = 20;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int RETRY_UNIT_MS = 35;
  localparam int RETRY_UNIT_CYCLES = (CLK_FREQ_HZ / 1000) * RETRY_UNIT_MS;
  localparam int NUM_PAGES = 2;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_RUN = 5'h02,
    ST_WAIT = 5'h04,
    ST_HOLD_OV = 5'h08,
    ST_HOLD_UV = 5'h10
  } vfrc_state_t;

endpackage

// *** vfrc_retry_timer.sv ***
// Purpose: Measures one retry interval of whole 35 ms units for one output.
// Assumes: start pulses at the beginning of each restart attempt; delay may settle after it.
// Notes: Own prescaler, so the interval is exact rather than off by a partial tick.
module vfrc_retry_timer #(
  parameter int TICK_CYCLES = vfrc_pkg::RETRY_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control
  input wire logic start,
  input wire logic [2:0] delay,
  // Status
  output logic done
);

  localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

  localparam logic [3:0] UNITS_MAX = 4'h8;

  logic [PW-1:0] pre_reg;
  logic [3:0] units_reg;
  wire tick = (pre_reg == PRE_LAST);
  wire units_full = (units_reg == UNITS_MAX);
  wire [3:0] need = {1'b0, delay};

  // Elapsed units count up from the attempt start, so the delay can be chosen at fault time.
  // The count saturates so that a long run never wraps into a false short interval.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pre_reg <= '0;
      units_reg <= 4'h0;
    end else if (start) begin
      pre_reg <= '0;
      units_reg <= 4'h0;
    end else if (!units_full) begin
      pre_reg <= tick ? '0 : pre_reg + 1'b1;
      units_reg <= tick ? units_reg + 4'h1 : units_reg;
    end
  end

  // Done rises one cycle ahead, so the restart edge falls on the interval boundary.
  assign done = (units_reg > need) | ((units_reg == need) & tick);

endmodule // vfrc_retry_timer

// *** vfrc_vout_fault_ctl.sv ***
// Purpose: Output overvoltage and undervoltage fault response for every output page.
// Assumes: Commands arrive already framed; vout_meas uses the threshold's 2^-13 V scaling.
// Notes: Clear-faults acts on all pages; a fault arriving in the same cycle stays set.
module vfrc_vout_fault_ctl #(
  parameter int NP = vfrc_pkg::NUM_PAGES,
  parameter int TICK_CYCLES = vfrc_pkg::RETRY_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [1:0] cmd_len,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_rdata,
  // Strap
  input wire logic [15:0] setpoint_strap_pin,
  // Power stage
  input wire logic bias_ok,
  input wire logic [NP-1:0] enable_cmd,
  input wire logic [NP-1:0] other_shutdown,
  input wire logic [NP-1:0] power_good,
  input wire logic [NP-1:0] ov_detect,
  input wire logic [NP*16-1:0] vout_meas,
  output logic [NP-1:0] output_enable,
  // Status
  output logic [NP-1:0] ov_fault_status,
  output logic [NP-1:0] uv_fault_status,
  // Alert line, open drain
  input wire logic alert_line_i,
  output logic alert_line_o,
  output logic alert_line_oe
);

  localparam int PW = (NP > 1) ? $clog2(NP) : 1;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] uv_default(input logic [15:0] v);
    logic [20:0] prod;
    prod = {5'h00, v} * 21'(vfrc_pkg::UV_SCALE_NUM);
    return 16'(prod / 21'(vfrc_pkg::UV_SCALE_DEN));
  endfunction

  function automatic logic act_disables(input logic [7:0] a);
    return a[vfrc_pkg::ACT_MODE_HI];
  endfunction

  function automatic logic act_retries(input logic [7:0] a);
    return a[vfrc_pkg::ACT_RETRY_HI:vfrc_pkg::ACT_RETRY_LO] == vfrc_pkg::RETRY_FOREVER;
  endfunction

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [PW-1:0] page_reg;
  logic [7:0] ov_act_reg [NP];
  logic [7:0] uv_act_reg [NP];
  logic [15:0] uv_lim_reg [NP];
  logic [NP-1:0] ov_stat_reg;
  logic [NP-1:0] uv_stat_reg;
  logic [NP-1:0] out_en_reg;
  vfrc_pkg::vfrc_state_t st_reg [NP];
  logic strap_load_reg;
  logic rsp_valid_reg;
  logic rsp_err_reg;
  logic [15:0] rsp_rdata_reg;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  wire is_page = (cmd_code == vfrc_pkg::CMD_PAGE);
  wire is_clear = (cmd_code == vfrc_pkg::CMD_CLEAR_FAULTS);
  wire is_ov_act = (cmd_code == vfrc_pkg::CMD_OV_FAULT_ACTION);
  wire is_uv_lim = (cmd_code == vfrc_pkg::CMD_UV_FAULT_THRESHOLD);
  wire is_uv_act = (cmd_code == vfrc_pkg::CMD_UV_FAULT_ACTION);
  wire byte_cmd = is_page | is_ov_act | is_uv_act;
  wire len_ok = (byte_cmd & (cmd_len == vfrc_pkg::LEN_BYTE))
              | (is_uv_lim & (cmd_len == vfrc_pkg::LEN_WORD))
              | (is_clear & cmd_write & (cmd_len == vfrc_pkg::LEN_SEND));
  wire page_ok = ~(is_page & cmd_write) | (32'(cmd_wdata[7:0]) < NP);
  wire cmd_ok = len_ok & page_ok;
  wire wr_ok = cmd_valid & cmd_write & cmd_ok;
  wire clear_faults = wr_ok & is_clear;
  wire [15:0] rd_data = is_page ? {{(16 - PW){1'b0}}, page_reg}
                      : is_ov_act ? {8'h00, ov_act_reg[page_reg]}
                      : is_uv_act ? {8'h00, uv_act_reg[page_reg]}
                      : is_uv_lim ? uv_lim_reg[page_reg]
                      : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      page_reg <= '0;
      rsp_valid_reg <= 1'b0;
      rsp_err_reg <= 1'b0;
      rsp_rdata_reg <= 16'h0000;
    end else begin
      if (wr_ok & is_page) begin
        page_reg <= cmd_wdata[PW-1:0];
      end
      rsp_valid_reg <= cmd_valid;
      rsp_err_reg <= cmd_valid & ~cmd_ok;
      rsp_rdata_reg <= (cmd_valid & ~cmd_write & cmd_ok) ? rd_data : 16'h0000;
    end
  end

  // The strap is sampled on the first clock after reset is released.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      strap_load_reg <= 1'b1;
    end else begin
      strap_load_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Per-page settings, faults and restart sequencing
  // ----------------------------------------------------------------------
  for (genvar p = 0; p < NP; p++) begin : g_page
    wire hit = (page_reg == PW'(p));
    wire wr_ov = wr_ok & hit & is_ov_act;
    wire wr_uv_act = wr_ok & hit & is_uv_act;
    wire wr_uv_lim = wr_ok & hit & is_uv_lim;
    wire en_ok = enable_cmd[p] & bias_ok & ~other_shutdown[p];
    wire running = (st_reg[p] == vfrc_pkg::ST_RUN);
    wire [15:0] vout = vout_meas[p*16 +: 16];
    // Unsigned compare keeps the threshold in 2^-13 V steps.
    wire uv_hit = running & power_good[p] & (vout < uv_lim_reg[p]);
    wire ov_hit = ov_detect[p];
    wire ov_off = running & ov_hit & act_disables(ov_act_reg[p]);
    wire uv_off = running & uv_hit & act_disables(uv_act_reg[p]);
    wire t_done;
    wire t_start;
    // The retry delay is latched from the action of the fault that caused the shutdown.
    logic [2:0] dly_reg;
    wire [2:0] fault_dly = ov_off
                         ? ov_act_reg[p][vfrc_pkg::ACT_DELAY_HI:vfrc_pkg::ACT_DELAY_LO]
                         : uv_act_reg[p][vfrc_pkg::ACT_DELAY_HI:vfrc_pkg::ACT_DELAY_LO];
    vfrc_pkg::vfrc_state_t st_next;

    always_comb begin
      st_next = st_reg[p];
      unique case (st_reg[p])
        vfrc_pkg::ST_OFF: begin
          if (en_ok) st_next = vfrc_pkg::ST_RUN;
        end
        vfrc_pkg::ST_RUN: begin
          if (!en_ok) begin
            st_next = vfrc_pkg::ST_OFF;
          end else if (ov_off) begin
            st_next = act_retries(ov_act_reg[p]) ? vfrc_pkg::ST_WAIT
                                                 : vfrc_pkg::ST_HOLD_OV;
          end else if (uv_off) begin
            st_next = act_retries(uv_act_reg[p]) ? vfrc_pkg::ST_WAIT
                                                 : vfrc_pkg::ST_HOLD_UV;
          end
        end
        vfrc_pkg::ST_WAIT: begin
          if (!en_ok) begin
            st_next = vfrc_pkg::ST_OFF;
          end else if (t_done) begin
            st_next = vfrc_pkg::ST_RUN;
          end
        end
        vfrc_pkg::ST_HOLD_OV: begin
          st_next = vfrc_pkg::ST_HOLD_OV;
        end
        vfrc_pkg::ST_HOLD_UV: begin
          if (clear_faults) st_next = vfrc_pkg::ST_OFF;
        end
        default: st_next = vfrc_pkg::ST_OFF;
      endcase
    end

    // Each entry into running is one restart attempt and restarts the interval.
    assign t_start = (st_next == vfrc_pkg::ST_RUN) & ~running;

    vfrc_retry_timer #(
      .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .start(t_start),
      .delay(dly_reg),
      .done(t_done)
    );

    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        ov_act_reg[p] <= vfrc_pkg::ACT_RESET;
        uv_act_reg[p] <= vfrc_pkg::ACT_RESET;
        uv_lim_reg[p] <= 16'h0000;
        st_reg[p] <= vfrc_pkg::ST_OFF;
        out_en_reg[p] <= 1'b0;
        ov_stat_reg[p] <= 1'b0;
        uv_stat_reg[p] <= 1'b0;
        dly_reg <= 3'h0;
      end else begin
        if (wr_ov) ov_act_reg[p] <= cmd_wdata[7:0];
        if (wr_uv_act) uv_act_reg[p] <= cmd_wdata[7:0];
        if (strap_load_reg) begin
          uv_lim_reg[p] <= uv_default(setpoint_strap_pin);
        end else if (wr_uv_lim) begin
          uv_lim_reg[p] <= cmd_wdata;
        end
        st_reg[p] <= st_next;
        out_en_reg[p] <= (st_next == vfrc_pkg::ST_RUN);
        if (ov_off | uv_off) dly_reg <= fault_dly;
        // A new fault wins over a clear in the same cycle.
        ov_stat_reg[p] <= ov_hit | (ov_stat_reg[p] & ~clear_faults);
        uv_stat_reg[p] <= uv_hit | (uv_stat_reg[p] & ~clear_faults);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign output_enable = out_en_reg;
  assign ov_fault_status = ov_stat_reg;
  assign uv_fault_status = uv_stat_reg;
  assign alert_line_o = 1'b0;
  // The line is only ever pulled low; the readback is left for wired-or observers.
  assign alert_line_oe = |{ov_stat_reg, uv_stat_reg};
  assign rsp_valid = rsp_valid_reg;
  assign rsp_err = rsp_err_reg;
  assign rsp_rdata = rsp_rdata_reg;

endmodule // vfrc_vout_fault_ctl

// *** vfrc_props.sv ***
// Purpose: Concurrent checks on the fault-response controller ports.
// Assumes: Page 0 stands for every page; one clock domain.
// Notes: Bound to the controller below the module.
module vfrc_props #(
  parameter int NP = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Command port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic rsp_valid,
  // Power stage
  input wire logic bias_ok,
  input wire logic [NP-1:0] enable_cmd,
  input wire logic [NP-1:0] other_shutdown,
  input wire logic [NP-1:0] power_good,
  input wire logic [NP-1:0] ov_detect,
  input wire logic [NP-1:0] output_enable,
  // Status
  input wire logic [NP-1:0] ov_fault_status,
  input wire logic [NP-1:0] uv_fault_status,
  input wire logic alert_line_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire clr = cmd_valid && cmd_code == vfrc_pkg::CMD_CLEAR_FAULTS;
  wire en_ok = bias_ok && enable_cmd[0] && !other_shutdown[0];
  a_rsp_next: assert property (cmd_valid |=> rsp_valid)
    else $error("response missing");
  a_rsp_idle: assert property (!cmd_valid |=> !rsp_valid)
    else $error("response without command");
  a_alert_or: assert property (alert_line_oe == ((|ov_fault_status) | (|uv_fault_status)))
    else $error("alert line not tied to status");
  a_ov_sets: assert property (ov_detect[0] |=> ov_fault_status[0] && alert_line_oe)
    else $error("overvoltage not latched");
  a_status_sticky: assert property (ov_fault_status[0] && !clr |=> ov_fault_status[0])
    else $error("status dropped without clear");
  a_uv_masked: assert property
    (!uv_fault_status[0] && !(power_good[0] && output_enable[0]) |=> !uv_fault_status[0])
    else $error("undervoltage while masked");
  a_start_needs: assert property ($rose(output_enable[0]) |-> $past(en_ok))
    else $error("start without enable");
  a_off_stays: assert property (!output_enable[0] && !en_ok |=> !output_enable[0])
    else $error("restart while commanded off");
endmodule // vfrc_props

bind vfrc_vout_fault_ctl vfrc_props #(.NP(NP)) u_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .rsp_valid(rsp_valid), .bias_ok(bias_ok), .enable_cmd(enable_cmd),
  .other_shutdown(other_shutdown), .power_good(power_good), .ov_detect(ov_detect),
  .output_enable(output_enable), .ov_fault_status(ov_fault_status),
  .uv_fault_status(uv_fault_status), .alert_line_oe(alert_line_oe));

// *** vfrc_host_model.sv ***
// Purpose: Management-bus host issuing byte, word and send-only commands.
// Assumes: The answer stands for the one cycle after the taking edge.
// Notes: Released code and data lines show inverted values so stale data is never read as live.
module vfrc_host_model (
  // Clock
  input wire logic sys_clk,
  // Command
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [1:0] cmd_len,
  output logic [15:0] cmd_wdata,
  // Response
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'hFF;
    cmd_len = 2'h3;
    cmd_wdata = 16'hFFFF;
  end
  task automatic xfer(input logic wr, input logic [7:0] c, input logic [1:0] l,
                      input logic [15:0] d, output logic [15:0] rd, output logic er);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = c;
    cmd_len = l;
    cmd_wdata = d;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~d;
    rd = rsp_rdata;
    er = (rsp_valid !== 1'b1) || rsp_err;
  endtask
endmodule // vfrc_host_model

// *** test_vout_fault_response_ctl.sv ***
// Purpose: Self-checking bench for the output fault-response controller.
// Assumes: The 35 ms unit is shortened to TICK cycles.
// Notes: An overvoltage hold only leaves by reset, so groups reset between them.
module test_vout_fault_response_ctl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NP = 2;
  localparam int TICK = 10;
  localparam int STRAP = 8192;
  localparam logic [7:0] PG = vfrc_pkg::CMD_PAGE;
  localparam logic [7:0] CLR = vfrc_pkg::CMD_CLEAR_FAULTS;
  localparam logic [7:0] OVA = vfrc_pkg::CMD_OV_FAULT_ACTION;
  localparam logic [7:0] UVT = vfrc_pkg::CMD_UV_FAULT_THRESHOLD;
  localparam logic [7:0] UVA = vfrc_pkg::CMD_UV_FAULT_ACTION;
  localparam logic [1:0] B = vfrc_pkg::LEN_BYTE;
  localparam logic [1:0] W = vfrc_pkg::LEN_WORD;
  logic sys_clk, sys_rst, bias_ok, cmd_valid, cmd_write, rsp_valid, rsp_err, al_oe, er;
  logic [7:0] cmd_code;
  logic [1:0] cmd_len;
  logic [15:0] cmd_wdata, rsp_rdata, rd;
  logic [NP-1:0] en, osd, pgood, ovd, oe, ovs, uvs;
  logic [NP*16-1:0] vm;
  int failures, n_compared, cyc, t0;
  vfrc_vout_fault_ctl #(.NP(NP), .TICK_CYCLES(TICK)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .setpoint_strap_pin(16'(STRAP)),
    .bias_ok(bias_ok), .enable_cmd(en), .other_shutdown(osd), .power_good(pgood),
    .ov_detect(ovd), .vout_meas(vm), .output_enable(oe), .ov_fault_status(ovs),
    .uv_fault_status(uvs), .alert_line_i(~al_oe), .alert_line_o(), .alert_line_oe(al_oe));
  vfrc_host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_rdata(rsp_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [1:0] l, input logic [15:0] d);
    host.xfer(1'b1, c, l, d, rd, er);
  endtask
  task automatic rdc(input logic [7:0] c, input logic [1:0] l, input logic [15:0] exp);
    host.xfer(1'b0, c, l, 16'h0000, rd, er);
    chk(rd, exp);
  endtask
  // Bounded wait for an output to run again.
  task automatic wait_hi(input int p);
    for (int i = 0; i < 200 && oe[p] !== 1'b1; i++) tick(1);
  endtask
  task automatic pulse_ov(input int p);
    ovd[p] = 1'b1;
    tick(1);
    ovd[p] = 1'b0;
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    {en, osd, pgood, ovd} = '0;
    tick(12);
    sys_rst = 1'b0;
    tick(2);
  endtask
  initial begin
    bias_ok = 1'b1;
    vm = {NP{16'h2000}};
    do_reset();
    for (int p = 0; p < NP; p++) begin
      wr(PG, B, 16'(p));
      rdc(OVA, B, 16'h0080);
      rdc(UVA, B, 16'h0080);
      rdc(UVT, W, 16'(STRAP * 85 / 100));
    end
    wr(UVA, B, 16'hFFBF);
    rdc(UVA, B, 16'h00BF);
    wr(PG, B, 16'h0000);
    rdc(UVA, B, 16'h0080);
    wr(UVT, W, 16'hFFFF);
    rdc(UVT, W, 16'hFFFF);
    host.xfer(1'b0, 8'h42, B, 16'h0000, rd, er);
    chk(16'(er), 16'h0001);
    host.xfer(1'b1, OVA, W, 16'h00C0, rd, er);
    chk(16'(er), 16'h0001);
    rdc(OVA, B, 16'h0080);
    en = 2'b01;
    for (int m = 0; m < 4; m++) begin
      wr(OVA, B, {8'h00, 2'(m), 6'h38});
      wait_hi(0);
      pulse_ov(0);
      chk(oe[0], 16'(m < 2));
      chk({ovs[0], al_oe}, 16'h0003);
      wr(CLR, vfrc_pkg::LEN_SEND, 16'h0000);
      chk({ovs[0], al_oe}, 16'h0000);
    end
    wr(OVA, B, 16'h0080);
    wait_hi(0);
    pulse_ov(0);
    wr(CLR, vfrc_pkg::LEN_SEND, 16'h0000);
    tick(TICK * 9);
    chk(oe[0], 16'h0000);
    wr(PG, B, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      en[1] = 1'b0;
      wr(OVA, B, 16'h00B8 | 16'(i * 7));
      en[1] = 1'b1;
      wait_hi(1);
      t0 = cyc;
      pulse_ov(1);
      wait_hi(1);
      chk(16'(cyc - t0), 16'((i * 7 + 1) * TICK));
    end
    pulse_ov(1);
    osd[1] = 1'b1;
    tick(TICK * 9);
    chk(oe[1], 16'h0000);
    do_reset();
    wr(PG, B, 16'h0000);
    wr(UVT, W, 16'h1000);
    rdc(UVT, W, 16'h1000);
    vm[15:0] = 16'h0800;
    en = 2'b01;
    wait_hi(0);
    tick(5);
    chk(uvs[0], 16'h0000);
    pgood[0] = 1'b1;
    tick(2);
    chk({uvs[0], oe[0]}, 16'h0002);
    pgood[0] = 1'b0;
    tick(TICK * 9);
    chk(oe[0], 16'h0000);
    wr(CLR, vfrc_pkg::LEN_SEND, 16'h0000);
    tick(3);
    chk({uvs[0], oe[0]}, 16'h0001);
    // Undervoltage retry must use its own delay field, not the overvoltage one.
    en[0] = 1'b0;
    wr(UVA, B, 16'h00B9);
    en[0] = 1'b1;
    wait_hi(0);
    t0 = cyc;
    pgood[0] = 1'b1;
    tick(1);
    pgood[0] = 1'b0;
    chk({uvs[0], oe[0]}, 16'h0002);
    wait_hi(0);
    chk(16'(cyc - t0), 16'(2 * TICK));
    wrap_up();
  end
endmodule // test_vout_fault_response_ctl
